// ---- hdl/sdram_params.svh ----
`ifndef SDRAM_PARAMS_SVH
`define SDRAM_PARAMS_SVH
// Functional notes
// - First write word is taken with WRITE, then one word per edge.
// - A finished fixed burst ignores further data; pins stay undriven.
// - Full-page write runs until stopped, wrapping last column to 0.
// - A new WRITE may come any edge, truncating the old burst.
// - A READ stops the write burst; data from that edge is ignored.
// - BURST TERMINATE drops its own data; previous word was the last.
// - Bit ten selects all banks, else the bank-select pins pick one.
// - CKE low with NOP and nothing running enters power-down.
// - CKE low during an access suspends the next internal edge.
// - CKE sampled high resumes internal clocking on the next edge.
// - Write-burst-mode bit set makes every WRITE a single column.
// - Access to another bank is accepted during an auto-precharge burst.
// - READ interrupting auto-precharge READ starts that bank's precharge.
// - WRITE interrupting auto-precharge READ cuts it and precharges then.
// - WRITE with auto precharge closes its row when the burst ends.
// - Byte mask acts on write data with zero latency.
`define REG_CFG 12'h000
`define REG_STATUS 12'h004
`define REG_ERR 12'h008
`define CFG_MASK 32'h0000_021F
`define CFG_RESET 32'h0000_0012
`define CFG_BL_LSB 0
`define CFG_BT_BIT 3
`define CFG_CL3_BIT 4
`define CFG_WBM_BIT 9
`define BL_FULL 3'h7
`define AP_BIT 10
`define BANKS 4
`endif

// ---- hdl/sdram_pkg.sv ----
package sdram_pkg;
  typedef enum logic [2:0] {
    cmd_nop, cmd_active, cmd_read, cmd_write, cmd_bst, cmd_pre, cmd_other
  } cmd_t;
  typedef enum logic [1:0] {pd_off, pd_precharge, pd_active} pd_state_t;
endpackage

// ---- hdl/cfg_if.sv ----
`timescale 1ns/1ps
interface cfg_if;
  logic [2:0] burst_code;
  logic interleave;
  logic cl3;
  logic write_burst_mode_bit;
  logic [8:0] status;
  logic err_set;
  modport regs (output burst_code, interleave, cl3, write_burst_mode_bit,
                input status, err_set);
  modport core (input burst_code, interleave, cl3, write_burst_mode_bit,
                output status, err_set);
endinterface

// ---- hdl/apb_regs.sv ----
`timescale 1ns/1ps
`include "sdram_params.svh"
module apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cfg_if.regs cfg
);
  logic [31:0] cfg_reg;
  logic err_flag;
  wire hit_cfg = paddr == `REG_CFG;
  wire hit_status = paddr == `REG_STATUS;
  wire hit_err = paddr == `REG_ERR;
  wire mapped = hit_cfg | hit_status | hit_err;
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready & pwrite;
  wire err_clr = commit & hit_err & pwdata[0];
  wire [31:0] rd_mux = hit_cfg ? cfg_reg :
    hit_status ? {23'h0, cfg.status} :
    hit_err ? {31'h0, err_flag} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  // Set beats clear so an error in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CFG_RESET;
      err_flag <= 1'b0;
    end else begin
      if (commit && hit_cfg)
        cfg_reg <= pwdata & `CFG_MASK;
      err_flag <= cfg.err_set | (err_flag & ~err_clr);
    end
  end

  assign cfg.burst_code = cfg_reg[`CFG_BL_LSB +: 3];
  assign cfg.interleave = cfg_reg[`CFG_BT_BIT];
  assign cfg.cl3 = cfg_reg[`CFG_CL3_BIT];
  assign cfg.write_burst_mode_bit = cfg_reg[`CFG_WBM_BIT];
endmodule // apb_regs

// ---- hdl/bank_state.sv ----
`timescale 1ns/1ps
module bank_state #(
  parameter int ROW_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic open,
  input wire logic close,
  input wire logic [ROW_W-1:0] row_in,
  output logic active,
  output logic [ROW_W-1:0] row
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      row <= '0;
    end else if (en && close) begin
      active <= 1'b0;
    end else if (en && open) begin
      active <= 1'b1;
      row <= row_in;
    end
  end
endmodule // bank_state

// ---- hdl/sdram_write_precharge_powerdown.sv ----
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sdram_params.svh"
module sdram_write_precharge_powerdown #(
  parameter int ROW_W = 12,
  parameter int COL_W = 8,
  parameter int DQ_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] addr,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [DQ_W/8-1:0] dqm,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [DQ_W/8-1:0] dq_oe
);
  import sdram_pkg::*;
  localparam int NB = `BANKS;
  localparam int LANES = DQ_W / 8;
  localparam int IDX_W = 2 + ROW_W + COL_W;

  cfg_if cfg ();

  apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg.regs)
  );

  function automatic logic [COL_W-1:0] last_of(input logic [2:0] code);
    case (code)
      3'h1: last_of = COL_W'(1);
      3'h2: last_of = COL_W'(3);
      3'h3: last_of = COL_W'(7);
      `BL_FULL: last_of = '1;
      default: last_of = '0;
    endcase
  endfunction

  function automatic logic [COL_W-1:0] col_at(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] i,
    input logic [COL_W-1:0] last,
    input logic inter,
    input logic full);
    logic [COL_W-1:0] s;
    s = inter ? (start ^ i) : (start + i);
    col_at = full ? start + i : ((start & ~last) | (s & last));
  endfunction

  logic cke_q;
  pd_state_t pd_state;
  pd_state_t next_pd;
  logic wr_active, wr_ap, wr_full;
  logic [1:0] wr_bank;
  logic [COL_W-1:0] wr_start, wr_cnt, wr_last;
  logic rd_active, rd_ap, rd_full;
  logic [1:0] rd_bank;
  logic [COL_W-1:0] rd_start, rd_cnt, rd_last;
  logic [DQ_W-1:0] pipe0, pipe1;
  logic v0, v1;
  logic [LANES-1:0] dqm_q;
  logic [NB-1:0] bank_active;
  logic [ROW_W-1:0] bank_row [NB];
  logic [DQ_W-1:0] mem [1 << IDX_W];

  wire [2:0] rcw = {ras_n, cas_n, we_n};
  cmd_t cmd;
  assign cmd = cs_n ? cmd_nop :
    (rcw == 3'h7) ? cmd_nop :
    (rcw == 3'h3) ? cmd_active :
    (rcw == 3'h5) ? cmd_read :
    (rcw == 3'h4) ? cmd_write :
    (rcw == 3'h6) ? cmd_bst :
    (rcw == 3'h2) ? cmd_pre : cmd_other;
  wire [1:0] cmd_bank = {bank_select_high, bank_select_low};
  wire [COL_W-1:0] cmd_col = addr[COL_W-1:0];
  wire ap_sel = addr[`AP_BIT];

  // Internal edge: CKE seen one edge earlier gates this one
  wire run = clk_en & cke_q & (pd_state == pd_off);
  wire is_acc = (cmd == cmd_read) | (cmd == cmd_write);
  wire bad_acc = run & is_acc & ~bank_active[cmd_bank];
  wire new_write = run & (cmd == cmd_write) & bank_active[cmd_bank];
  wire new_read = run & (cmd == cmd_read) & bank_active[cmd_bank];
  wire new_acc = new_write | new_read;
  wire pre_cmd = run & (cmd == cmd_pre);
  wire [NB-1:0] pre_hit = !pre_cmd ? '0 :
    ap_sel ? '1 : NB'(1) << cmd_bank;
  wire stop_cmd = is_acc | (cmd == cmd_bst);
  wire wr_cont = wr_active & run & ~stop_cmd & ~pre_hit[wr_bank];
  wire rd_cont = rd_active & run & ~stop_cmd & ~pre_hit[rd_bank];
  wire busy = wr_active | rd_active | v0 | v1;

  wire full_page = cfg.burst_code == `BL_FULL;
  wire [COL_W-1:0] burst_last = last_of(cfg.burst_code);
  // Single-column writes regardless of programmed length
  wire [COL_W-1:0] wr_len_last =
    cfg.write_burst_mode_bit ? '0 : burst_last;
  wire wr_full_new = full_page & ~cfg.write_burst_mode_bit;
  wire new_wr_end = new_write & ~wr_full_new & (wr_len_last == '0);
  wire new_rd_end = new_read & ~full_page & (burst_last == '0);
  wire wr_end = wr_cont & ~wr_full & (wr_cnt == wr_last);
  wire rd_end = rd_cont & ~rd_full & (rd_cnt == rd_last);

  wire we_now = new_write | wr_cont;
  wire [1:0] we_bank = new_write ? cmd_bank : wr_bank;
  wire [COL_W-1:0] we_col = new_write ? cmd_col :
    col_at(wr_start, wr_cnt, wr_last, cfg.interleave, wr_full);
  wire [IDX_W-1:0] we_idx = {we_bank, bank_row[we_bank], we_col};
  wire rd_now = new_read | rd_cont;
  wire [1:0] rb_now = new_read ? cmd_bank : rd_bank;
  wire [COL_W-1:0] rc_now = new_read ? cmd_col :
    col_at(rd_start, rd_cnt, rd_last, cfg.interleave, rd_full);
  wire [DQ_W-1:0] rd_word = mem[{rb_now, bank_row[rb_now], rc_now}];

  // Auto precharge at burst end or when another access cuts in
  wire wr_old_close = wr_active & wr_ap & (wr_end | new_acc);
  wire rd_old_close = rd_active & rd_ap & (rd_end | new_acc);
  wire new_close = ap_sel & (new_wr_end | new_rd_end);

  for (genvar b = 0; b < NB; b++) begin : g_bank
    wire close_b = pre_hit[b] |
      (wr_old_close & (wr_bank == 2'(b))) |
      (rd_old_close & (rd_bank == 2'(b))) |
      (new_close & (cmd_bank == 2'(b)));
    wire open_b = run & (cmd == cmd_active) & (cmd_bank == 2'(b));
    bank_state #(.ROW_W(ROW_W)) u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .en(clk_en),
      .open(open_b),
      .close(close_b),
      .row_in(addr),
      .active(bank_active[b]),
      .row(bank_row[b])
    );
  end

  wire pd_enter = (pd_state == pd_off) & ~cke & (cmd == cmd_nop) & ~busy;
  always_comb begin
    case (pd_state)
      pd_off: next_pd = !pd_enter ? pd_off :
        (|bank_active) ? pd_active : pd_precharge;
      pd_precharge, pd_active: next_pd = cke ? pd_off : pd_state;
      default: next_pd = pd_off;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke_q <= 1'b1;
      pd_state <= pd_off;
    end else if (clk_en) begin
      cke_q <= cke;
      pd_state <= next_pd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_active <= 1'b0;
      wr_ap <= 1'b0;
      wr_full <= 1'b0;
      wr_bank <= 2'h0;
      wr_start <= '0;
      wr_cnt <= '0;
      wr_last <= '0;
    end else if (new_write) begin
      wr_active <= ~new_wr_end;
      wr_ap <= ap_sel;
      wr_full <= wr_full_new;
      wr_bank <= cmd_bank;
      wr_start <= cmd_col;
      wr_cnt <= COL_W'(1);
      wr_last <= wr_len_last;
    end else if (wr_cont) begin
      wr_cnt <= wr_cnt + 1'b1;
      wr_active <= ~wr_end;
    end else if (run) begin
      wr_active <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_active <= 1'b0;
      rd_ap <= 1'b0;
      rd_full <= 1'b0;
      rd_bank <= 2'h0;
      rd_start <= '0;
      rd_cnt <= '0;
      rd_last <= '0;
    end else if (new_read) begin
      rd_active <= ~new_rd_end;
      rd_ap <= ap_sel;
      rd_full <= full_page;
      rd_bank <= cmd_bank;
      rd_start <= cmd_col;
      rd_cnt <= COL_W'(1);
      rd_last <= burst_last;
    end else if (rd_cont) begin
      rd_cnt <= rd_cnt + 1'b1;
      rd_active <= ~rd_end;
    end else if (run) begin
      rd_active <= 1'b0;
    end
  end

  // Read output pipeline holds while suspended, so DQ stays driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe0 <= '0;
      pipe1 <= '0;
      v0 <= 1'b0;
      v1 <= 1'b0;
      dqm_q <= '0;
      dq_out <= '0;
      dq_oe <= '0;
    end else if (run) begin
      pipe0 <= rd_word;
      pipe1 <= pipe0;
      v0 <= rd_now;
      v1 <= v0 & ~new_write;
      dqm_q <= dqm;
      dq_out <= cfg.cl3 ? pipe1 : pipe0;
      dq_oe <= new_write ? '0 : {LANES{cfg.cl3 ? v1 : v0}} & ~dqm_q;
    end
  end

  // No reset on the array; contents are undefined until written
  always_ff @(posedge pclk) begin
    if (clk_en && we_now) begin
      for (int i = 0; i < LANES; i++) begin
        if (!dqm[i])
          mem[we_idx][i*8 +: 8] <= dq_in[i*8 +: 8];
      end
    end
  end

  assign cfg.status = {rd_active, wr_active,
    ~cke_q & (pd_state == pd_off) & busy,
    pd_state == pd_active, pd_state == pd_precharge, bank_active};
  assign cfg.err_set = clk_en & bad_acc;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wr_first_a: assert property (new_write |-> we_now && we_col == cmd_col
    && we_bank == cmd_bank) else $error("first word not taken");
  wr_idle_a: assert property (!wr_active && !new_write |-> !we_now)
    else $error("write outside burst");
  page_wrap_a: assert property (wr_cont && wr_full && (&we_col) ##1 wr_cont
    |-> we_col == '0) else $error("page did not wrap");
  wr_trunc_a: assert property (new_write && !new_wr_end |=> wr_active &&
    wr_bank == $past(cmd_bank) && wr_cnt == COL_W'(1))
    else $error("new write not started");
  rd_stop_a: assert property (run && cmd == cmd_read |-> !we_now ##1
    !wr_active) else $error("write kept after read");
  bst_drop_a: assert property (run && cmd == cmd_bst |-> !we_now ##1
    !wr_active) else $error("data taken on terminate");
  pre_all_a: assert property (pre_cmd && ap_sel |=> bank_active == '0)
    else $error("all-bank precharge missed");
  pd_entry_a: assert property (clk_en && pd_enter |=> pd_state ==
    ((|$past(bank_active)) ? pd_active : pd_precharge))
    else $error("power-down kind wrong");
  pd_quiet_a: assert property (pd_state != pd_off |-> !run && dq_oe == '0)
    else $error("active in power-down");
  suspend_hold_a: assert property (clk_en && !cke && pd_state == pd_off
    && busy ##1 clk_en |=> $stable(wr_cnt) && $stable(rd_cnt) &&
    $stable(dq_oe)) else $error("counters moved in suspend");
  resume_a: assert property (clk_en && cke && pd_state == pd_off |=>
    run || !clk_en) else $error("no resume after CKE high");
  single_wr_a: assert property (new_write && cfg.write_burst_mode_bit |=>
    !wr_active) else $error("single write ran on");
  ap_rd_cut_a: assert property (new_acc && rd_active && rd_ap &&
    rd_bank != cmd_bank |=> !bank_active[$past(rd_bank)])
    else $error("interrupted bank not closed");
  wr_ap_a: assert property (wr_end && wr_ap |=>
    !bank_active[$past(wr_bank)]) else $error("no auto precharge");

  wr_burst_c: cover property (new_write ##1 wr_cont [*3] ##1 !wr_active);
  pd_cycle_c: cover property (pd_state == pd_off ##1 pd_state != pd_off
    ##[1:20] pd_state == pd_off);
  suspend_c: cover property (wr_active && !cke_q && pd_state == pd_off);
  ap_cut_c: cover property (new_write && rd_active && rd_ap);
endmodule // sdram_write_precharge_powerdown

// ---- verification/sdram_ctrl_model.sv ----
`timescale 1ns/1ps
module sdram_ctrl_model (
  input wire logic pclk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [11:0] addr,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [1:0] dqm,
  output logic [15:0] dq_in
);
  import sdram_pkg::*;
  logic [3:0] pins;
  assign {cs_n, ras_n, cas_n, we_n} = pins;
  initial begin
    cke = 1'b1;
    pins = 4'h7;
    addr = 12'h000;
    {bank_select_high, bank_select_low} = 2'h0;
    dqm = 2'h0;
    dq_in = 16'h0000;
  end
  // Caller spaces commands: recovery, tRP, ACTIVE first
  // No truncating PRECHARGE is issued, so no mask pair is owed
  // Power-down lasts a few cycles, far below the refresh period
  task automatic cmd(input cmd_t c, input logic [1:0] b,
    input logic [11:0] a, input logic [15:0] d, input logic [1:0] m,
    input logic k);
    case (c)
      cmd_active: pins <= 4'h3;
      cmd_read: pins <= 4'h5;
      cmd_write: pins <= 4'h4;
      cmd_bst: pins <= 4'h6;
      cmd_pre: pins <= 4'h2;
      default: pins <= 4'h7;
    endcase
    {bank_select_high, bank_select_low} <= b;
    addr <= a;
    dq_in <= d;
    dqm <= m;
    cke <= k;
    @(posedge pclk);
  endtask
  // Released bus flips so a stale word is never mistaken for data
  task automatic idle(input logic k);
    cmd(cmd_nop, 2'h0, 12'h000, ~dq_in, 2'h0, k);
  endtask
endmodule // sdram_ctrl_model

// ---- verification/sdram_write_precharge_powerdown_tb_top.sv ----
`timescale 1ns/1ps
module sdram_write_precharge_powerdown_tb_top;
  import sdram_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
  logic [11:0] paddr, addr;
  logic [31:0] pwdata, prdata, prd;
  logic [1:0] dqm, dq_oe;
  logic [15:0] dq_in, dq_out;
  logic [15:0] mem [4][256];
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int mk = -1;
  logic ap = 1'b0;
  // Idle edges between READ and the first sampled word: CAS latency - 1
  int cas_wait = 1;
  sdram_write_precharge_powerdown dut (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .addr(addr),
    .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high),
    .dqm(dqm),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );
  sdram_ctrl_model m (
    .pclk(pclk),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .addr(addr),
    .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high),
    .dqm(dqm),
    .dq_in(dq_in)
  );
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    prd = prdata;
    chk("pslverr", {31'h0, a > 12'h008}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
    input string s);
    apb(1'b0, a, 32'h0000_0000);
    chk(s, e, prd);
  endtask
  // Shadow keeps the upper byte of the masked word
  task automatic wr(input logic [1:0] b, input logic [7:0] c, input int n,
    input logic [15:0] d, input int w);
    logic [7:0] col;
    for (int i = 0; i < n; i++) begin
      col = c + 8'(i);
      if (i < w)
        mem[b][col] = (i == mk) ? {mem[b][col][15:8], d[7:0]} : d;
      m.cmd(i == 0 ? cmd_write : cmd_nop, b, {1'b0, ap, 2'b00, c}, d,
        i == mk ? 2'b10 : 2'b00, 1'b1);
      d++;
    end
  endtask
  // Word i is sampled at edge READ+CL+i, before that edge moves it on
  task automatic rd_chk(input logic [1:0] b, input logic [7:0] c,
    input int n);
    m.cmd(cmd_read, b, {4'h0, c}, 16'hFFFF, 2'h0, 1'b1);
    repeat (cas_wait) m.idle(1'b1);
    for (int i = 0; i < n; i++) begin
      m.idle(1'b1);
      chk("dq_out", 32'(mem[b][c + 8'(i)]), 32'(dq_out));
      chk("dq_oe", 32'h0000_0003, 32'(dq_oe));
    end
  endtask
  task automatic t_regs();
    rchk(12'h000, 32'h0000_0012, "cfg reset");
    rchk(12'h004, 32'h0000_0000, "status reset");
    apb(1'b1, 12'h000, 32'h0000_0002);
    rchk(12'h000, 32'h0000_0002, "cfg");
    rchk(12'h00C, 32'h0000_0000, "unmapped");
    $display("regs done");
  endtask
  task automatic t_burst();
    m.cmd(cmd_active, 2'h0, 12'h001, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b1);
    wr(2'h0, 8'h0C, 4, 16'hC000, 4);
    wr(2'h0, 8'h04, 4, 16'hB000, 4);
    wr(2'h0, 8'h08, 5, 16'hA000, 4);
    mk = 1;
    wr(2'h0, 8'h04, 2, 16'hE000, 2);
    mk = -1;
    wr(2'h0, 8'h08, 2, 16'hD000, 2);
    rd_chk(2'h0, 8'h04, 4);
    rd_chk(2'h0, 8'h08, 4);
    rd_chk(2'h0, 8'h0C, 4);
    apb(1'b1, 12'h000, 32'h0000_0012);
    cas_wait = 2;
    rd_chk(2'h0, 8'h0C, 4);
    cas_wait = 1;
    apb(1'b1, 12'h000, 32'h0000_0002);
    $display("burst done");
  endtask
  task automatic t_susp();
    m.cmd(cmd_write, 2'h0, 12'h004, 16'h5000, 2'h0, 1'b1);
    m.cmd(cmd_nop, 2'h0, 12'h000, 16'h5001, 2'h0, 1'b0);
    m.cmd(cmd_nop, 2'h0, 12'h000, 16'h5FFF, 2'h0, 1'b1);
    m.cmd(cmd_nop, 2'h0, 12'h000, 16'h5002, 2'h0, 1'b1);
    m.cmd(cmd_nop, 2'h0, 12'h000, 16'h5003, 2'h0, 1'b1);
    for (int i = 0; i < 4; i++)
      mem[0][4 + i] = 16'h5000 + 16'(i);
    rd_chk(2'h0, 8'h04, 4);
    apb(1'b1, 12'h000, 32'h0000_0202);
    wr(2'h0, 8'h04, 4, 16'h6000, 1);
    rd_chk(2'h0, 8'h04, 4);
    $display("suspend and single write done");
  endtask
  task automatic t_page();
    apb(1'b1, 12'h000, 32'h0000_0007);
    m.cmd(cmd_active, 2'h1, 12'h002, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b1);
    wr(2'h1, 8'h00, 4, 16'h7000, 4);
    m.cmd(cmd_bst, 2'h1, 12'h000, 16'h7FFF, 2'h0, 1'b1);
    wr(2'h1, 8'hFE, 4, 16'h8000, 4);
    m.cmd(cmd_bst, 2'h1, 12'h000, 16'h8FFF, 2'h0, 1'b1);
    rd_chk(2'h1, 8'hFE, 5);
    m.cmd(cmd_bst, 2'h1, 12'h000, 16'h0000, 2'h0, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_0002);
    $display("full page done");
  endtask
  task automatic t_pre();
    m.cmd(cmd_active, 2'h2, 12'h003, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b1);
    ap = 1'b1;
    wr(2'h2, 8'h00, 4, 16'h9000, 4);
    ap = 1'b0;
    m.idle(1'b1);
    m.idle(1'b1);
    rchk(12'h004, 32'h0000_0003, "status autopre");
    m.cmd(cmd_pre, 2'h1, 12'h000, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b1);
    rchk(12'h004, 32'h0000_0001, "status pre one");
    m.cmd(cmd_write, 2'h1, 12'h000, 16'h1234, 2'h0, 1'b1);
    m.idle(1'b1);
    rchk(12'h008, 32'h0000_0001, "err set");
    apb(1'b1, 12'h008, 32'h0000_0001);
    rchk(12'h008, 32'h0000_0000, "err clear");
    m.cmd(cmd_pre, 2'h2, 12'h400, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b1);
    rchk(12'h004, 32'h0000_0000, "status pre all");
    $display("precharge done");
  endtask
  task automatic t_pd();
    m.idle(1'b0);
    m.cmd(cmd_active, 2'h2, 12'h005, 16'h0000, 2'h0, 1'b0);
    rchk(12'h004, 32'h0000_0010, "precharge pd");
    m.idle(1'b1);
    m.cmd(cmd_active, 2'h3, 12'h006, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b0);
    rchk(12'h004, 32'h0000_0028, "active pd");
    m.idle(1'b1);
    m.idle(1'b1);
    rchk(12'h004, 32'h0000_0008, "pd exit");
    $display("power-down done");
  endtask
  task automatic t_cap();
    m.cmd(cmd_active, 2'h0, 12'h001, 16'h0000, 2'h0, 1'b1);
    m.idle(1'b1);
    m.idle(1'b1);
    m.cmd(cmd_read, 2'h0, 12'h408, 16'hFFFF, 2'h3, 1'b1);
    m.idle(1'b1);
    m.cmd(cmd_write, 2'h3, 12'h000, 16'hA100, 2'h0, 1'b1);
    // Seen at the next edge: what the WRITE edge launched
    m.cmd(cmd_bst, 2'h3, 12'h000, 16'hAFFF, 2'h0, 1'b1);
    chk("dq_oe cut", 32'h0000_0000, 32'(dq_oe));
    mem[3][0] = 16'hA100;
    rchk(12'h004, 32'h0000_0008, "status cap");
    rd_chk(2'h3, 8'h00, 1);
    $display("concurrent done");
  endtask
  // Engine frozen for one edge mid-burst; the flipped word must not land
  task automatic t_freeze();
    m.cmd(cmd_write, 2'h3, 12'h010, 16'hF000, 2'h0, 1'b1);
    clk_en <= 1'b0;
    m.idle(1'b1);
    clk_en <= 1'b1;
    for (int i = 1; i < 4; i++)
      m.cmd(cmd_nop, 2'h3, 12'h000, 16'hF000 + 16'(i), 2'h0, 1'b1);
    for (int i = 0; i < 4; i++)
      mem[3][16 + i] = 16'hF000 + 16'(i);
    rd_chk(2'h3, 8'h10, 4);
    $display("clock enable done");
  endtask
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_burst();
    t_susp();
    t_page();
    t_pre();
    t_pd();
    t_cap();
    t_freeze();
    report_and_stop();
  end
endmodule // sdram_write_precharge_powerdown_tb_top
